// file: verilog/cap_sense_pkg.sv
// Package with constants and types for the capacitive sensing counter logic
package cap_sense_pkg;
  // Counter widths
  localparam int BYTE_W = 8;
  localparam int RLX_W = 6;
  localparam int WORD_W = 16;
  localparam int SEQ_W = 12;
  localparam int DIV_W = 8;
  localparam int DIV_SEL_W = 4;
  // Control word bit positions
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_SD_BIT = 3;
  localparam int CTL_W = 8;
  // Terminal and reset values
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_TC = 8'hFF;
  localparam logic [RLX_W-1:0] RLX_ZERO = 6'h00;
  localparam logic [RLX_W-1:0] RLX_ONE = 6'h01;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;
  localparam logic [WORD_W-1:0] WORD_TC = 16'hFFFF;
  localparam logic [SEQ_W-1:0] SEQ_SEED = 12'h001;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
  localparam logic [DIV_SEL_W-1:0] DIV_MAX_SEL = 4'h8;
  localparam logic [SEQ_W-1:0] TAP8_MASK = 12'h0B8;
  localparam logic [SEQ_W-1:0] TAP12_MASK = 12'hE08;
  localparam logic [SEQ_W-1:0] LOW8_MASK = 12'h0FF;
  // Measurement methods
  typedef enum logic [2:0] {
    METH_CHARGE = 3'h0,
    METH_RELAX1 = 3'h1,
    METH_RELAX2 = 3'h3,
    METH_SUCC = 3'h2,
    METH_SIGMA = 3'h6
  } method_t;
  // Measurement sequencer states, Gray along idle-run-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } state_t;
endpackage : cap_sense_pkg

// file: verilog/sync_two_stage.sv
// Two flip-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module sync_two_stage (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic first_ff;
    logic second_ff;
  } sync_state_t;
  sync_state_t st_reg;
  sync_state_t st_next;

  // First stage feeds only the second stage, never other logic
  always_comb begin
    st_next = st_reg;
    st_next.first_ff = async_in;
    st_next.second_ff = st_reg.first_ff;
  end

  // Register both stages
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.second_ff;
endmodule : sync_two_stage

// file: verilog/prs_gen.sv
// Prescaled pseudo-random sequence generator driving the sense switch
`timescale 1ns/1ps
module prs_gen (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic prs_run,
  input wire logic prs_long,
  input wire logic [cap_sense_pkg::DIV_SEL_W-1:0] prs_div_sel,
  output logic prs_tick,
  output logic prs_bit
);
  import cap_sense_pkg::*;
  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic [SEQ_W-1:0] lfsr;
    logic tick;
  } prs_state_t;
  prs_state_t st_reg;
  prs_state_t st_next;
  logic [DIV_W:0] div_span;
  logic [SEQ_W-1:0] taps;

  // Divide by a power of two, selects above 8 clamp to 256
  always_comb begin
    st_next = st_reg;
    div_span = (prs_div_sel > DIV_MAX_SEL) ? (9'h001 << DIV_MAX_SEL)
                                           : (9'h001 << prs_div_sel);
    taps = prs_long ? TAP12_MASK : TAP8_MASK;
    st_next.tick = 1'b0;
    if (!prs_run) begin
      st_next.div_cnt = DIV_ZERO;
      st_next.lfsr = SEQ_SEED;
    end else if ({1'b0, st_reg.div_cnt} >= div_span - 9'h001) begin
      st_next.div_cnt = DIV_ZERO;
      st_next.tick = 1'b1;
      // Galois shift; short mode keeps only the low byte live
      st_next.lfsr = (st_reg.lfsr >> 1) ^ (st_reg.lfsr[0] ? taps : SEQ_SEED ^ SEQ_SEED);
      if (!prs_long) begin
        st_next.lfsr = st_next.lfsr & LOW8_MASK;
      end
    end else begin
      st_next.div_cnt = st_reg.div_cnt + DIV_ONE;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '{div_cnt: DIV_ZERO, lfsr: SEQ_SEED, tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign prs_tick = st_reg.tick;
  assign prs_bit = st_reg.lfsr[0];
endmodule : prs_gen

// file: verilog/cap_sense_count_logic.sv
// Counting and sequencing core of the capacitive sensing front end
`timescale 1ns/1ps
module cap_sense_count_logic (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [cap_sense_pkg::CTL_W-1:0] sense_control_zero,
  input wire logic [2:0] method_sel,
  input wire logic one_shot,
  input wire logic [cap_sense_pkg::BYTE_W-1:0] interval_len,
  input wire logic [cap_sense_pkg::RLX_W-1:0] relax_cycles,
  input wire logic comparator_zero_input,
  input wire logic relaxation_oscillator,
  input wire logic internal_main_oscillator,
  input wire logic interval_timer_start,
  input wire logic prs_run,
  input wire logic prs_long,
  input wire logic [cap_sense_pkg::DIV_SEL_W-1:0] prs_div_sel,
  input wire logic prs_switch_sel,
  output logic sense_switch,
  output logic [cap_sense_pkg::BYTE_W-1:0] count_low_byte,
  output logic [cap_sense_pkg::BYTE_W-1:0] count_high_byte,
  output logic count_overflow,
  output logic result_ready,
  output logic delay_event,
  output logic interval_end_event
);
  import cap_sense_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    state_t state;
    logic en_prev;
    logic ro_prev;
    logic imo_prev;
    logic start_prev;
    logic armed;
    logic sd_stopped;
    logic [BYTE_W-1:0] cnt_lo;
    logic [BYTE_W-1:0] cnt_hi;
    logic [RLX_W-1:0] cnt_rlx;
    logic [BYTE_W-1:0] cap_lo;
    logic [BYTE_W-1:0] cap_hi;
    logic ovf;
    logic ready;
    logic delay_ev;
    logic end_ev;
    logic switch_out;
  } core_state_t;
  core_state_t st_reg;
  core_state_t st_next;

  logic cmp_sync;
  logic ro_sync;
  logic imo_sync;
  logic prs_tick;
  logic prs_bit;
  logic enable;
  logic sd_mode;
  logic ro_rise;
  logic imo_rise;
  logic [WORD_W-1:0] word_cnt;
  logic [WORD_W-1:0] word_inc;
  logic lo_tc;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for comparator and both oscillator clocks
  sync_two_stage u_cmp_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(comparator_zero_input),
    .sync_out(cmp_sync)
  );

  // Oscillator edges are sampled, so they must run below half of core_clk
  sync_two_stage u_ro_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(relaxation_oscillator),
    .sync_out(ro_sync)
  );

  sync_two_stage u_imo_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(internal_main_oscillator),
    .sync_out(imo_sync)
  );

  // Sequence generator for the sense switch
  prs_gen u_prs (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .prs_run(prs_run),
    .prs_long(prs_long),
    .prs_div_sel(prs_div_sel),
    .prs_tick(prs_tick),
    .prs_bit(prs_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls and shared counter arithmetic
  assign enable = sense_control_zero[CTL_EN_BIT];
  assign sd_mode = sense_control_zero[CTL_SD_BIT];
  assign ro_rise = ro_sync & ~st_reg.ro_prev;
  assign imo_rise = imo_sync & ~st_reg.imo_prev;
  assign word_cnt = {st_reg.cnt_hi, st_reg.cnt_lo};
  assign word_inc = word_cnt + WORD_ONE;
  assign lo_tc = (st_reg.cnt_lo == interval_len);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.en_prev = enable;
    st_next.ro_prev = ro_sync;
    st_next.imo_prev = imo_sync;
    st_next.start_prev = interval_timer_start;
    st_next.delay_ev = 1'b0;
    st_next.end_ev = 1'b0;
    // Switch follows the sequence or a plain toggle at the prescaled rate
    if (prs_switch_sel) begin
      st_next.switch_out = prs_bit;
    end else if (prs_tick) begin
      st_next.switch_out = ~st_reg.switch_out;
    end
    if (!enable) begin
      // Disable clears the counters and re-arms for the next run
      st_next.state = ST_IDLE;
      st_next.cnt_lo = BYTE_ZERO;
      st_next.cnt_hi = BYTE_ZERO;
      st_next.cnt_rlx = RLX_ZERO;
      st_next.sd_stopped = 1'b0;
      st_next.armed = 1'b1;
    end else begin
      unique case (st_reg.state)
        ST_IDLE: begin
          // Only a fresh rise of enable starts a measurement
          if (!st_reg.en_prev && st_reg.armed) begin
            st_next.state = ST_RUN;
            st_next.armed = 1'b0;
            st_next.ready = 1'b0;
            st_next.ovf = 1'b0;
          end
        end
        ST_RUN: begin
          unique case (method_sel)
            METH_RELAX1: begin
              // Low counter on oscillator clock, high counter on sensed oscillator
              if (imo_rise) begin
                st_next.cnt_lo = st_reg.cnt_lo + 8'h01;
              end
              if (ro_rise) begin
                st_next.cnt_hi = st_reg.cnt_hi + 8'h01;
                if (st_reg.cnt_hi == BYTE_TC) begin
                  st_next.ovf = 1'b1;
                end
              end
              if (imo_rise && lo_tc) begin
                st_next.cap_lo = BYTE_ZERO;
                st_next.cap_hi = st_reg.cnt_hi;
                st_next.ready = 1'b1;
                st_next.end_ev = 1'b1;
                st_next.cnt_lo = BYTE_ZERO;
                st_next.cnt_hi = BYTE_ZERO;
                if (one_shot) begin
                  st_next.state = ST_DONE;
                end
              end
            end
            METH_RELAX2: begin
              // Chained word on oscillator clock until six-bit count is reached
              if (imo_rise) begin
                {st_next.cnt_hi, st_next.cnt_lo} = word_inc;
                if (word_cnt == WORD_TC) begin
                  st_next.ovf = 1'b1;
                end
              end
              if (ro_rise) begin
                st_next.cnt_rlx = st_reg.cnt_rlx + RLX_ONE;
                if (st_reg.cnt_rlx + RLX_ONE == relax_cycles) begin
                  {st_next.cap_hi, st_next.cap_lo} = word_cnt;
                  st_next.ready = 1'b1;
                  st_next.end_ev = 1'b1;
                  st_next.cnt_rlx = RLX_ZERO;
                  {st_next.cnt_hi, st_next.cnt_lo} = WORD_ZERO;
                  if (one_shot) begin
                    st_next.state = ST_DONE;
                  end
                end
              end
            end
            METH_CHARGE: begin
              // Count oscillator clocks until the comparator trips
              if (imo_rise) begin
                {st_next.cnt_hi, st_next.cnt_lo} = word_inc;
                if (word_cnt == WORD_TC) begin
                  st_next.ovf = 1'b1;
                end
              end
              if (cmp_sync) begin
                {st_next.cap_hi, st_next.cap_lo} = word_cnt;
                st_next.ready = 1'b1;
                st_next.end_ev = 1'b1;
                if (one_shot) begin
                  st_next.state = ST_DONE;
                end else begin
                  {st_next.cnt_hi, st_next.cnt_lo} = WORD_ZERO;
                end
              end
            end
            METH_SUCC: begin
              // Six-bit delay on oscillator clock, one event when it expires
              if (imo_rise) begin
                st_next.cnt_rlx = st_reg.cnt_rlx + RLX_ONE;
                if (st_reg.cnt_rlx + RLX_ONE == relax_cycles) begin
                  st_next.delay_ev = 1'b1;
                  st_next.ready = 1'b1;
                  st_next.state = ST_DONE;
                end
              end
            end
            METH_SIGMA: begin
              // Gated count; a start fall ends the run at either comparator level
              if (!sd_mode) begin
                st_next.state = ST_RUN;
              end else if (st_reg.sd_stopped) begin
                st_next.state = ST_DONE;
              end else if (cmp_sync && interval_timer_start) begin
                {st_next.cnt_hi, st_next.cnt_lo} = word_inc;
                if (word_cnt == WORD_TC) begin
                  st_next.ovf = 1'b1;
                end
              end else if (cmp_sync && st_reg.start_prev && !interval_timer_start) begin
                st_next.sd_stopped = 1'b1;
              end else if (!cmp_sync && !interval_timer_start && st_reg.start_prev) begin
                st_next.sd_stopped = 1'b1;
              end
              if (st_reg.start_prev && !interval_timer_start) begin
                {st_next.cap_hi, st_next.cap_lo} = word_cnt;
                st_next.ready = 1'b1;
                st_next.end_ev = 1'b1;
                st_next.state = ST_DONE;
              end
            end
            default: begin
              st_next.state = ST_IDLE;
            end
          endcase
        end
        ST_DONE: begin
          // Counters frozen until enable is cleared
          st_next.state = ST_DONE;
        end
        default: begin
          st_next.state = ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign sense_switch = st_reg.switch_out;
  assign count_low_byte = st_reg.cap_lo;
  assign count_high_byte = st_reg.cap_hi;
  assign count_overflow = st_reg.ovf;
  assign result_ready = st_reg.ready;
  assign delay_event = st_reg.delay_ev;
  assign interval_end_event = st_reg.end_ev;
endmodule : cap_sense_count_logic

// file: dv/cap_sense_count_logic_monitor.sv
// Port-level checker for the capacitive sensing counter logic
`timescale 1ns/1ps
module cap_sense_count_logic_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [cap_sense_pkg::CTL_W-1:0] sense_control_zero,
  input wire logic [2:0] method_sel,
  input wire logic interval_timer_start,
  input wire logic prs_run,
  input wire logic [cap_sense_pkg::DIV_SEL_W-1:0] prs_div_sel,
  input wire logic prs_switch_sel,
  input wire logic sense_switch,
  input wire logic [cap_sense_pkg::BYTE_W-1:0] count_low_byte,
  input wire logic [cap_sense_pkg::BYTE_W-1:0] count_high_byte,
  input wire logic count_overflow,
  input wire logic result_ready,
  input wire logic delay_event,
  input wire logic interval_end_event
);
  import cap_sense_pkg::*;
  // Decoded enables
  wire logic en = sense_control_zero[CTL_EN_BIT];
  wire logic sd_on = en && sense_control_zero[CTL_SD_BIT] && method_sel == METH_SIGMA;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  property p_evt_pulse; interval_end_event |=> !interval_end_event; endproperty
  a_evt_pulse: assert property (p_evt_pulse)
    else $error("end event too wide");
  property p_evt_ready; interval_end_event |-> result_ready; endproperty
  a_evt_ready: assert property (p_evt_ready)
    else $error("end event without result");
  // The delay method posts its result with the delay pulse, not an end pulse
  property p_ready_src;
    $rose(result_ready) |-> interval_end_event || delay_event;
  endproperty
  a_ready_src: assert property (p_ready_src)
    else $error("result without end event");
  property p_dly_pulse; delay_event |=> !delay_event; endproperty
  a_dly_pulse: assert property (p_dly_pulse)
    else $error("delay event too wide");
  property p_dly_src; delay_event |-> method_sel == METH_SUCC; endproperty
  a_dly_src: assert property (p_dly_src)
    else $error("delay event in wrong method");
  // A fresh start drops the old result, a held result does not move
  property p_start_clr;
    $rose(en) && !$past(sys_rst) |=> !result_ready && !count_overflow;
  endproperty
  a_start_clr: assert property (p_start_clr)
    else $error("start kept old result");
  property p_hold;
    result_ready && $past(result_ready) |-> $stable({count_high_byte, count_low_byte});
  endproperty
  a_hold: assert property (p_hold)
    else $error("held result changed");
  property p_sd_end;
    sd_on && !result_ready && $fell(interval_timer_start) |-> ##[0:2] interval_end_event;
  endproperty
  a_sd_end: assert property (p_sd_end)
    else $error("start fall did not end run");
  property p_toggle;
    (prs_run && !prs_switch_sel && prs_div_sel == 4'h0)[*4] |->
      sense_switch != $past(sense_switch);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("switch missed a tick");
endmodule : cap_sense_count_logic_monitor

// file: dv/cap_front_model.sv
// Behavioural comparator and oscillator sources facing the counter logic
`timescale 1ns/1ps
module cap_front_model #(
  parameter int RO_HALF = 2,
  parameter int IMO_HALF = 5
) (
  input wire logic core_clk,
  input wire logic osc_run,
  input wire logic cmp_req,
  output logic comparator_zero_input = 1'b0,
  output logic relaxation_oscillator = 1'b0,
  output logic internal_main_oscillator = 1'b0
);
  int ro_cnt = 0;
  int imo_cnt = 0;
  // Oscillators stand low while stopped, so every run starts from a known phase
  always @(posedge core_clk) begin
    comparator_zero_input <= cmp_req;
    ro_cnt <= (!osc_run || ro_cnt == RO_HALF - 1) ? 0 : ro_cnt + 1;
    imo_cnt <= (!osc_run || imo_cnt == IMO_HALF - 1) ? 0 : imo_cnt + 1;
    if (!osc_run) begin
      relaxation_oscillator <= 1'b0;
      internal_main_oscillator <= 1'b0;
    end else begin
      relaxation_oscillator <= relaxation_oscillator ^ (ro_cnt == RO_HALF - 1);
      internal_main_oscillator <= internal_main_oscillator ^ (imo_cnt == IMO_HALF - 1);
    end
  end
endmodule : cap_front_model

// file: dv/test_cap_sense_count_logic.sv
// Self-checking bench for the capacitive sensing counter logic
`timescale 1ns/1ps
module test_cap_sense_count_logic;
  import cap_sense_pkg::*;
  localparam int RO_H = 2;
  localparam int IMO_H = 5;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [CTL_W-1:0] sense_control_zero = 8'h00;
  logic [2:0] method_sel = 3'h0;
  logic one_shot = 1'b1;
  logic [BYTE_W-1:0] interval_len = 8'h00;
  logic [RLX_W-1:0] relax_cycles = 6'h00;
  logic interval_timer_start = 1'b0;
  logic prs_run = 1'b0;
  logic prs_long = 1'b0;
  logic [DIV_SEL_W-1:0] prs_div_sel = 4'h0;
  logic prs_switch_sel = 1'b0;
  logic osc_run = 1'b0;
  logic cmp_req = 1'b0;
  logic comparator_zero_input, relaxation_oscillator, internal_main_oscillator;
  logic sense_switch, count_overflow, result_ready, delay_event, interval_end_event;
  logic [BYTE_W-1:0] count_low_byte, count_high_byte;
  logic [16:0] res;
  logic c1 = 1'b0;
  logic c2 = 1'b0;
  int num_errors = 0;
  int checks = 0;
  int seed = 32;
  int sd_cnt = 0;
  int n;
  assign res = {count_overflow, count_high_byte, count_low_byte};
  cap_sense_count_logic dut_u (.core_clk, .sys_rst, .sense_control_zero, .method_sel,
    .one_shot, .interval_len, .relax_cycles, .comparator_zero_input, .relaxation_oscillator,
    .internal_main_oscillator, .interval_timer_start, .prs_run, .prs_long, .prs_div_sel,
    .prs_switch_sel, .sense_switch, .count_low_byte, .count_high_byte, .count_overflow,
    .result_ready, .delay_event, .interval_end_event);
  cap_front_model #(.RO_HALF(RO_H), .IMO_HALF(IMO_H)) front_u (.core_clk, .osc_run,
    .cmp_req, .comparator_zero_input, .relaxation_oscillator, .internal_main_oscillator);
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // Reference count: comparator seen through two stages, gated by start and mode
  always @(posedge core_clk) begin
    if (sense_control_zero[CTL_EN_BIT] && sense_control_zero[CTL_SD_BIT]
        && method_sel == METH_SIGMA && interval_timer_start && c2)
      sd_cnt++;
    c2 = c1;
    c1 = comparator_zero_input;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic int rises_before(input int ha, input int hb, input int k);
    return (ha * (2 * k - 1) + hb - 1) / (2 * hb);
  endfunction : rises_before
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // A missing result ends the run rather than hanging it
  task automatic wait_ready(input int lim);
    for (int i = 0; i < lim && result_ready !== 1'b1; i++)
      @(negedge core_clk);
    if (result_ready !== 1'b1) begin
      num_errors++;
      report_and_stop();
    end
  endtask : wait_ready
  task automatic begin_run(input logic [2:0] m, input logic [7:0] c, input logic [7:0] il,
      input logic [5:0] rc);
    @(posedge core_clk);
    sense_control_zero <= 8'h00;
    method_sel <= m;
    interval_len <= il;
    relax_cycles <= rc;
    osc_run <= 1'b0;
    cmp_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    sense_control_zero <= c;
    repeat (3) @(posedge core_clk);
    osc_run <= 1'b1;
    sd_cnt = 0;
  endtask : begin_run
  task automatic sigma_run(input logic [7:0] c, input int len, input logic lng);
    @(posedge core_clk);
    prs_long <= lng;
    begin_run(METH_SIGMA, c, 8'h00, 6'h00);
    repeat (2) @(posedge core_clk);
    interval_timer_start <= 1'b1;
    for (int i = 0; i < len; i++) begin
      @(posedge core_clk);
      cmp_req <= ($random(seed) % 3) != 0;
    end
    interval_timer_start <= 1'b0;
  endtask : sigma_run
  task automatic osc_case(input logic [2:0] m, input logic [7:0] il, input logic [5:0] rc,
      input int trip, input int exp);
    begin_run(m, 8'h01, il, rc);
    if (trip > 0) begin
      repeat (trip) @(posedge core_clk);
      cmp_req <= 1'b1;
    end
    wait_ready(4000);
    check(res, 17'(exp));
    repeat (40) @(negedge core_clk);
    check(res, 17'(exp));
  endtask : osc_case
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int p;
    logic prev;
    logic [16:0] keep;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    prs_run <= 1'b1;
    sigma_run(8'h09, 511, 1'b0);
    wait_ready(2000);
    check(res, 17'(sd_cnt));
    sigma_run(8'h09, 1023, 1'b1);
    wait_ready(2000);
    check(res, 17'(sd_cnt));
    // Enable still high after the interval: a second window must not count
    keep = res;
    @(posedge core_clk);
    cmp_req <= 1'b1;
    interval_timer_start <= 1'b1;
    repeat (20) @(posedge core_clk);
    interval_timer_start <= 1'b0;
    repeat (5) @(negedge core_clk);
    check(res, keep);
    sigma_run(8'h01, 50, 1'b0);
    repeat (5) @(negedge core_clk);
    check(res, 17'h0);
    osc_case(METH_RELAX1, 8'h0F, 6'h00, 0, rises_before(IMO_H, RO_H, 16) * 256);
    n = rises_before(IMO_H, RO_H, 128);
    osc_case(METH_RELAX1, 8'h7F, 6'h00, 0, (n > 255 ? 65536 : 0) + (n % 256) * 256);
    osc_case(METH_RELAX2, 8'h00, 6'h05, 0, rises_before(RO_H, IMO_H, 5));
    osc_case(METH_RELAX2, 8'h00, 6'h00, 0, rises_before(RO_H, IMO_H, 64));
    osc_case(METH_CHARGE, 8'h00, 6'h00, 2 * IMO_H * 20 + 10, 21);
    begin_run(METH_SUCC, 8'h01, 8'h00, 6'h08);
    for (int t = 0; t < 3000 && delay_event !== 1'b1; t++)
      @(negedge core_clk);
    check(17'(delay_event), 17'h1);
    // Toggle mode: one switch change per prescaled tick at every division
    for (int s = 0; s < 10; s++) begin
      p = 1 << (s > 8 ? 8 : s);
      @(posedge core_clk);
      prs_div_sel <= (s > 8) ? 4'hF : 4'(s);
      repeat (520) @(negedge core_clk);
      n = 0;
      prev = sense_switch;
      repeat (8 * p) begin
        @(negedge core_clk);
        n += (sense_switch !== prev);
        prev = sense_switch;
      end
      check(17'(n), 17'h8);
    end
    report_and_stop();
  end
endmodule : test_cap_sense_count_logic
bind cap_sense_count_logic cap_sense_count_logic_monitor mon_u (.core_clk, .sys_rst,
  .sense_control_zero, .method_sel, .interval_timer_start, .prs_run, .prs_div_sel,
  .prs_switch_sel, .sense_switch, .count_low_byte, .count_high_byte, .count_overflow,
  .result_ready, .delay_event, .interval_end_event);
